// >>> plc_host.sv
// Host end: register-driven management bus master and low-speed pin control.
`timescale 1ns/100ps
`default_nettype none
module plc_host #(
	parameter int QUARTER_CYC = plc_pkg::SCL_QUARTER_CYC,
	parameter logic [6:0] DEV_ADDR = plc_pkg::BUS_ADDR
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	plc_link_if.host_end link,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [7:0] rdata_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	localparam logic [15:0] Q_LAST = 16'(QUARTER_CYC - 1);
	logic [2:0] s1_r, s2_r, s3_r, pin_r, pin_q_r, agree;
	logic sda_f, attn_f, pres_f;
	assign agree = ~(s2_r ^ s3_r);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= plc_pkg::HOST_PIN_IDLE;
			s2_r <= plc_pkg::HOST_PIN_IDLE;
			s3_r <= plc_pkg::HOST_PIN_IDLE;
			pin_r <= plc_pkg::HOST_PIN_IDLE;
			pin_q_r <= plc_pkg::HOST_PIN_IDLE;
		end else begin
			s1_r <= {link.sda, link.attention_n, link.module_present_n};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= (pin_r & ~agree) | (s2_r & agree);
			pin_q_r <= pin_r;
		end
	end
	assign {sda_f, attn_f, pres_f} = pin_r;

	// ----------------------------------------------------------------
	// Bus master
	// ----------------------------------------------------------------
	plc_pkg::plc_mst_e st_r;
	logic [15:0] qcnt_r;
	logic [1:0] q_r;
	logic [1:0] idx_r;
	logic [2:0] bc_r;
	logic [7:0] tx_r, rx_r, rdat_r, ptr_r, wdat_r;
	logic rd_mode_r, with_data_r, ack_r, nack_r, scl_oe_r, sda_oe_r;
	logic tick, go, rx, done_ev;
	assign tick = (st_r != plc_pkg::MST_IDLE) && (qcnt_r >= Q_LAST);
	assign go = we_i && (addr_i == plc_pkg::H_CMD) && (st_r == plc_pkg::MST_IDLE);
	assign rx = rd_mode_r && (idx_r == 2'h1);
	assign done_ev = tick && (st_r == plc_pkg::MST_STOP) && (q_r == 2'h3);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			qcnt_r <= 16'h0000;
		end else if (tick || st_r == plc_pkg::MST_IDLE) begin
			qcnt_r <= 16'h0000;
		end else begin
			qcnt_r <= qcnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= plc_pkg::MST_IDLE;
			q_r <= 2'h0;
			idx_r <= 2'h0;
			bc_r <= 3'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			rdat_r <= 8'h00;
			rd_mode_r <= 1'b0;
			with_data_r <= 1'b0;
			ack_r <= 1'b0;
			nack_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (st_r == plc_pkg::MST_IDLE) begin
			q_r <= 2'h0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			if (go) begin
				st_r <= plc_pkg::MST_START;
				rd_mode_r <= wdata_i[plc_pkg::CMD_READ_BIT];
				with_data_r <= wdata_i[plc_pkg::CMD_DATA_BIT];
				idx_r <= 2'h0;
				nack_r <= 1'b0;
			end
		end else if (tick) begin
			q_r <= q_r + 2'h1;
			case (st_r)
				plc_pkg::MST_START: begin
					if (q_r == 2'h1) sda_oe_r <= 1'b1;
					if (q_r == 2'h2) scl_oe_r <= 1'b1;
					if (q_r == 2'h3) begin
						st_r <= plc_pkg::MST_BIT;
						tx_r <= {DEV_ADDR, rd_mode_r};
						bc_r <= 3'h0;
					end
				end
				plc_pkg::MST_BIT: begin
					if (q_r == 2'h0) sda_oe_r <= rx ? 1'b0 : ~tx_r[7];
					if (q_r == 2'h1) scl_oe_r <= 1'b0;
					if (q_r == 2'h2 && rx) rx_r <= {rx_r[6:0], sda_f};
					if (q_r == 2'h3) begin
						scl_oe_r <= 1'b1;
						tx_r <= {tx_r[6:0], 1'b0};
						bc_r <= bc_r + 3'h1;
						if (bc_r == 3'h7) st_r <= plc_pkg::MST_ACK;
					end
				end
				plc_pkg::MST_ACK: begin
					// A single-byte read always ends with a not-acknowledge.
					if (q_r == 2'h0) sda_oe_r <= 1'b0;
					if (q_r == 2'h1) scl_oe_r <= 1'b0;
					if (q_r == 2'h2) ack_r <= ~sda_f;
					if (q_r == 2'h3) begin
						scl_oe_r <= 1'b1;
						bc_r <= 3'h0;
						if (rx) begin
							rdat_r <= rx_r;
							st_r <= plc_pkg::MST_STOP;
						end else if (!ack_r) begin
							nack_r <= 1'b1;
							st_r <= plc_pkg::MST_STOP;
						end else if (idx_r == 2'h0) begin
							idx_r <= 2'h1;
							tx_r <= ptr_r;
							st_r <= plc_pkg::MST_BIT;
						end else if (idx_r == 2'h1 && with_data_r) begin
							idx_r <= 2'h2;
							tx_r <= wdat_r;
							st_r <= plc_pkg::MST_BIT;
						end else begin
							st_r <= plc_pkg::MST_STOP;
						end
					end
				end
				plc_pkg::MST_STOP: begin
					if (q_r == 2'h0) sda_oe_r <= 1'b1;
					if (q_r == 2'h1) scl_oe_r <= 1'b0;
					if (q_r == 2'h2) sda_oe_r <= 1'b0;
					if (q_r == 2'h3) st_r <= plc_pkg::MST_IDLE;
				end
				default: st_r <= plc_pkg::MST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers, pins and interrupt
	// ----------------------------------------------------------------
	logic [3:0] ctrl_r;
	logic sel_n_r, rst_n_r, init_oe_r, init_r, wait_r;
	logic [2:0] irq_stat_r, irq_en_r, ev, clr;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_r <= plc_pkg::H_CTRL_RST;
			sel_n_r <= 1'b1;
			rst_n_r <= 1'b1;
			init_oe_r <= 1'b0;
			init_r <= 1'b0;
			ptr_r <= 8'h00;
			wdat_r <= 8'h00;
			irq_en_r <= 3'h0;
		end else if (we_i) begin
			if (addr_i == plc_pkg::H_CTRL) begin
				ctrl_r <= wdata_i[3:0];
				// One select line per module; this end drives only its own.
				sel_n_r <= ~wdata_i[plc_pkg::CTRL_SEL_BIT];
				rst_n_r <= ~wdata_i[plc_pkg::CTRL_RST_BIT];
				// Software must not change these while a module sits in the slot.
				init_oe_r <= wdata_i[plc_pkg::CTRL_INIT_OE_BIT];
				init_r <= wdata_i[plc_pkg::CTRL_INIT_BIT];
			end else if (addr_i == plc_pkg::H_PTR) begin
				ptr_r <= wdata_i;
			end else if (addr_i == plc_pkg::H_WDATA) begin
				wdat_r <= wdata_i;
			end else if (addr_i == plc_pkg::H_IRQ_EN) begin
				irq_en_r <= wdata_i[2:0];
			end
		end
	end

	// Status from the module is meaningless between a reset and its completion attention.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wait_r <= 1'b1;
		end else if (~rst_n_r || (pres_f != pin_q_r[0])) begin
			wait_r <= 1'b1;
		end else if (~attn_f) begin
			wait_r <= 1'b0;
		end
	end

	assign ev = {pres_f != pin_q_r[0], ~attn_f & pin_q_r[1], done_ev};
	assign clr = (we_i && addr_i == plc_pkg::H_IRQ_CLR) ? wdata_i[2:0] : 3'h0;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat_r <= 3'h0;
			irq_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
			irq_o <= |(irq_stat_r & irq_en_r);
			if (!re_i) begin
				rdata_o <= 8'h00;
			end else if (addr_i == plc_pkg::H_CTRL) begin
				rdata_o <= {4'h0, ctrl_r};
			end else if (addr_i == plc_pkg::H_PTR) begin
				rdata_o <= ptr_r;
			end else if (addr_i == plc_pkg::H_WDATA) begin
				rdata_o <= wdat_r;
			end else if (addr_i == plc_pkg::H_RDATA) begin
				rdata_o <= rdat_r;
			end else if (addr_i == plc_pkg::H_STATUS) begin
				rdata_o <= {3'h0, wait_r, ~attn_f, ~pres_f, nack_r, st_r != plc_pkg::MST_IDLE};
			end else if (addr_i == plc_pkg::H_IRQ_STAT) begin
				rdata_o <= {5'h00, irq_stat_r};
			end else if (addr_i == plc_pkg::H_IRQ_EN) begin
				rdata_o <= {5'h00, irq_en_r};
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

	assign link.host_scl_oe = scl_oe_r;
	assign link.host_sda_oe = sda_oe_r;
	assign link.module_select_n = sel_n_r;
	assign link.module_reset_n = rst_n_r;
	assign link.host_init_oe = init_oe_r;
	assign link.host_init_o = init_r;
endmodule : plc_host
`default_nettype wire

// >>> plc_link_chk.sv
// Assertions on the low-speed control link between host and module.
`timescale 1ns/100ps
`default_nettype none
module plc_link_chk #(
	parameter int RESET_MIN_CYC = plc_pkg::RESET_MIN_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic host_init_oe,
	input wire logic init_control_select,
	input wire logic attention_n,
	input wire logic module_present_n,
	input wire logic mod_sda_oe,
	input wire logic mod_attn_oe,
	input wire logic mod_present_oe
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic [15:0] low_cnt_r;
	logic long_w;
	// The margin covers the pin synchroniser, so a long count always means a full reset was taken.
	// The count is as wide as the module's own reset counter, so the documented minimum fits too.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			low_cnt_r <= 16'h0000;
		end else if (module_reset_n) begin
			low_cnt_r <= 16'h0000;
		end else if (low_cnt_r != 16'hFFFF) begin
			low_cnt_r <= low_cnt_r + 16'h0001;
		end
	end
	assign long_w = (low_cnt_r >= 16'(RESET_MIN_CYC + 8));
	sequence quiet_then_attn;
		!mod_attn_oe [*8] ##[1:40] mod_attn_oe;
	endsequence
	chk_powerup_done: assert property ($rose(rst_b_i) |-> quiet_then_attn)
		else $error("no completion after power-up");
	chk_reset_done: assert property ($rose(module_reset_n) && long_w |=> quiet_then_attn)
		else $error("no completion after module reset");
	chk_reset_quiet: assert property (long_w |-> !mod_attn_oe)
		else $error("attention held during full reset");
	chk_idle_no_sda: assert property (module_select_n [*8] |-> !mod_sda_oe)
		else $error("deselected module drives data");
	chk_sda_when_sel: assert property ($rose(mod_sda_oe) |-> !scl && !module_select_n)
		else $error("data driven outside selected clock low");
	chk_present_low: assert property (mod_present_oe && !module_present_n)
		else $error("presence not grounded");
	chk_init_pullup: assert property (!host_init_oe |-> init_control_select)
		else $error("undriven init select not high");
	chk_attn_drain: assert property (!mod_attn_oe |-> attention_n)
		else $error("attention low while released");
endmodule : plc_link_chk
`default_nettype wire

// >>> plc_link_if.sv
// Low-speed control link between host board and pluggable module.
`timescale 1ns/100ps
`default_nettype none
interface plc_link_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic mod_sda_oe;
	logic mod_attn_oe;
	logic mod_present_oe;
	logic module_select_n;
	logic module_reset_n;
	logic host_init_oe;
	logic host_init_o;
	logic scl;
	logic sda;
	logic init_control_select;
	logic attention_n;
	logic module_present_n;

	// Open-drain wires resolve to low while any party enables its driver, high through the pull-up otherwise.
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | mod_sda_oe);
	assign attention_n = ~mod_attn_oe;
	assign module_present_n = ~mod_present_oe;
	// The module's own pull-up gives software control while the host leaves the pin undriven.
	assign init_control_select = host_init_oe ? host_init_o : 1'b1;

	modport module_end (
		input scl,
		input sda,
		input module_select_n,
		input module_reset_n,
		input init_control_select,
		output mod_sda_oe,
		output mod_attn_oe,
		output mod_present_oe
	);

	modport host_end (
		output host_scl_oe,
		output host_sda_oe,
		output module_select_n,
		output module_reset_n,
		output host_init_oe,
		output host_init_o,
		input sda,
		input attention_n,
		input module_present_n
	);
endinterface : plc_link_if
`default_nettype wire

// >>> plc_module.sv
// Module end: management bus slave, hardware reset, power mode and attention logic.
`timescale 1ns/100ps
`default_nettype none
module plc_module #(
	parameter int RESET_MIN_CYC = plc_pkg::RESET_MIN_CYC,
	parameter int INIT_CYC = plc_pkg::INIT_CYC,
	parameter logic [6:0] DEV_ADDR = plc_pkg::BUS_ADDR
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	plc_link_if.module_end link,
	input wire logic [7:0] fault_i,
	output logic high_power_o,
	output logic ready_o
);
	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_LAST = 16'(RESET_MIN_CYC - 1);
	localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);
	logic [4:0] pin_raw;
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [4:0] s3_r;
	logic [4:0] pin_r;
	logic [4:0] agree;
	logic scl_f, sda_f, sel_n_f, rst_pin_f, init_f;
	logic scl_q_r, sda_q_r;
	logic rise, fall, start, stop;

	assign pin_raw = {link.scl, link.sda, link.module_select_n, link.module_reset_n, link.init_control_select};
	assign agree = ~(s2_r ^ s3_r);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= plc_pkg::MOD_PIN_IDLE;
			s2_r <= plc_pkg::MOD_PIN_IDLE;
			s3_r <= plc_pkg::MOD_PIN_IDLE;
			pin_r <= plc_pkg::MOD_PIN_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= (pin_r & ~agree) | (s2_r & agree);
			scl_q_r <= scl_f;
			sda_q_r <= sda_f;
		end
	end
	assign {scl_f, sda_f, sel_n_f, rst_pin_f, init_f} = pin_r;
	assign rise = scl_f & ~scl_q_r;
	assign fall = ~scl_f & scl_q_r;
	assign start = scl_f & scl_q_r & sda_q_r & ~sda_f;
	assign stop = scl_f & scl_q_r & ~sda_q_r & sda_f;

	// ----------------------------------------------------------------
	// Hardware reset and initialization
	// ----------------------------------------------------------------
	// Pulses shorter than the minimum are glitches and leave all settings alone.
	logic [15:0] rcnt_r;
	logic hold_r;
	logic [15:0] icnt_r;
	logic not_ready_r;
	logic init_done;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rcnt_r <= 16'h0000;
			hold_r <= 1'b0;
		end else if (rst_pin_f) begin
			rcnt_r <= 16'h0000;
			hold_r <= 1'b0;
		end else if (rcnt_r >= RST_LAST) begin
			hold_r <= 1'b1;
		end else begin
			rcnt_r <= rcnt_r + 16'h0001;
		end
	end

	// Power-up runs the same sequence as a pin reset, so completion is always announced.
	assign init_done = not_ready_r && (icnt_r >= INIT_LAST);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			icnt_r <= 16'h0000;
			not_ready_r <= 1'b1;
		end else if (hold_r) begin
			icnt_r <= 16'h0000;
			not_ready_r <= 1'b1;
		end else if (init_done) begin
			not_ready_r <= 1'b0;
		end else if (not_ready_r) begin
			icnt_r <= icnt_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Management bus slave
	// ----------------------------------------------------------------
	plc_pkg::plc_slv_e st_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic mack_r;
	logic sda_oe_r;
	logic act;
	logic wr_en;
	logic rd_en;
	logic [7:0] rd_byte;
	logic int_pend_r;
	logic [7:0] fault_r;
	logic ctrl_hp_r;

	always_comb begin
		rd_byte = 8'h00;
		if (ptr_r == plc_pkg::MAP_STATUS) begin
			rd_byte[plc_pkg::ST_NOT_READY_BIT] = not_ready_r;
			rd_byte[plc_pkg::ST_INT_BIT] = int_pend_r;
		end else if (ptr_r == plc_pkg::MAP_FAULT) begin
			rd_byte = fault_r;
		end else if (ptr_r == plc_pkg::MAP_CONTROL) begin
			rd_byte[plc_pkg::CTL_HP_BIT] = ctrl_hp_r;
		end else if (ptr_r == plc_pkg::MAP_MODE) begin
			rd_byte[plc_pkg::MODE_INIT_BIT] = init_f;
			rd_byte[plc_pkg::MODE_HP_BIT] = high_power_o;
		end
	end

	assign act = ~hold_r & ~sel_n_f & ~start & ~stop & fall;
	assign wr_en = act && (st_r == plc_pkg::SLV_WR) && (cnt_r == 4'h8);
	assign rd_en = act && (((st_r == plc_pkg::SLV_ADDR_ACK) && rw_r) || ((st_r == plc_pkg::SLV_RD_ACK) && mack_r));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= plc_pkg::SLV_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (hold_r) begin
			st_r <= plc_pkg::SLV_IDLE;
			ptr_r <= 8'h00;
			sda_oe_r <= 1'b0;
		end else if (sel_n_f) begin
			st_r <= plc_pkg::SLV_IDLE;
			sda_oe_r <= 1'b0;
		end else if (start) begin
			st_r <= plc_pkg::SLV_ADDR;
			cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else if (stop) begin
			st_r <= plc_pkg::SLV_IDLE;
			sda_oe_r <= 1'b0;
		end else if (rise) begin
			if (st_r == plc_pkg::SLV_ADDR || st_r == plc_pkg::SLV_PTR || st_r == plc_pkg::SLV_WR) begin
				sh_r <= {sh_r[6:0], sda_f};
				cnt_r <= cnt_r + 4'h1;
			end else if (st_r == plc_pkg::SLV_RD) begin
				cnt_r <= cnt_r + 4'h1;
			end else if (st_r == plc_pkg::SLV_RD_ACK) begin
				mack_r <= ~sda_f;
			end
		end else if (fall) begin
			if (rd_en) begin
				st_r <= plc_pkg::SLV_RD;
				cnt_r <= 4'h0;
				tx_r <= rd_byte;
				ptr_r <= ptr_r + 8'h01;
				sda_oe_r <= ~rd_byte[7];
			end else begin
				case (st_r)
					plc_pkg::SLV_ADDR: begin
						if (cnt_r == 4'h8) begin
							if (sh_r[7:1] == DEV_ADDR) begin
								st_r <= plc_pkg::SLV_ADDR_ACK;
								rw_r <= sh_r[0];
								sda_oe_r <= 1'b1;
							end else begin
								st_r <= plc_pkg::SLV_IDLE;
							end
						end
					end
					plc_pkg::SLV_ADDR_ACK: begin
						st_r <= plc_pkg::SLV_PTR;
						cnt_r <= 4'h0;
						sda_oe_r <= 1'b0;
					end
					plc_pkg::SLV_PTR: begin
						if (cnt_r == 4'h8) begin
							ptr_r <= sh_r;
							st_r <= plc_pkg::SLV_PTR_ACK;
							sda_oe_r <= 1'b1;
						end
					end
					plc_pkg::SLV_PTR_ACK, plc_pkg::SLV_WR_ACK: begin
						st_r <= plc_pkg::SLV_WR;
						cnt_r <= 4'h0;
						sda_oe_r <= 1'b0;
					end
					plc_pkg::SLV_WR: begin
						if (cnt_r == 4'h8) begin
							ptr_r <= ptr_r + 8'h01;
							st_r <= plc_pkg::SLV_WR_ACK;
							sda_oe_r <= 1'b1;
						end
					end
					plc_pkg::SLV_RD: begin
						if (cnt_r == 4'h8) begin
							st_r <= plc_pkg::SLV_RD_ACK;
							sda_oe_r <= 1'b0;
						end else begin
							sda_oe_r <= ~tx_r[3'h7 - cnt_r[2:0]];
						end
					end
					plc_pkg::SLV_RD_ACK: begin
						st_r <= plc_pkg::SLV_IDLE;
						sda_oe_r <= 1'b0;
					end
					default: begin
						st_r <= plc_pkg::SLV_IDLE;
						sda_oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Memory map state and pins
	// ----------------------------------------------------------------
	// Reading a flag byte clears it, but an event in the same cycle still sets it.
	logic attn_oe_r;
	logic present_oe_r;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_pend_r <= 1'b0;
			fault_r <= 8'h00;
			ctrl_hp_r <= 1'b0;
		end else if (hold_r) begin
			int_pend_r <= 1'b0;
			fault_r <= 8'h00;
			ctrl_hp_r <= 1'b0;
		end else begin
			if (init_done) begin
				int_pend_r <= 1'b1;
			end else if (rd_en && ptr_r == plc_pkg::MAP_STATUS) begin
				int_pend_r <= 1'b0;
			end
			fault_r <= ((rd_en && ptr_r == plc_pkg::MAP_FAULT) ? 8'h00 : fault_r) | fault_i;
			if (wr_en && ptr_r == plc_pkg::MAP_CONTROL) begin
				ctrl_hp_r <= sh_r[plc_pkg::CTL_HP_BIT];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			high_power_o <= 1'b0;
			ready_o <= 1'b0;
			attn_oe_r <= 1'b0;
			present_oe_r <= 1'b1;
		end else begin
			// A high init select (also the pulled-up default) waits for software.
			high_power_o <= init_f ? (ctrl_hp_r & ~not_ready_r) : ~not_ready_r;
			ready_o <= ~not_ready_r;
			attn_oe_r <= int_pend_r | (|fault_r);
			present_oe_r <= 1'b1;
		end
	end

	assign link.mod_sda_oe = sda_oe_r;
	assign link.mod_attn_oe = attn_oe_r;
	assign link.mod_present_oe = present_oe_r;
endmodule : plc_module
`default_nettype wire

// >>> plc_pkg.sv
// Shared constants and state types of the pluggable module low-speed control link.
package plc_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_MIN_NS = 10000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_NS = 2000;
	localparam int INIT_CYC = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS / CLK_PERIOD_NS < 1) ? 1 : SCL_QUARTER_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Management bus and module memory map
	// ----------------------------------------------------------------
	localparam logic [6:0] BUS_ADDR = 7'h50;
	localparam logic [7:0] MAP_STATUS = 8'h00;
	localparam logic [7:0] MAP_FAULT = 8'h01;
	localparam logic [7:0] MAP_CONTROL = 8'h02;
	localparam logic [7:0] MAP_MODE = 8'h03;
	localparam int ST_NOT_READY_BIT = 0;
	localparam int ST_INT_BIT = 1;
	localparam int CTL_HP_BIT = 0;
	localparam int MODE_INIT_BIT = 0;
	localparam int MODE_HP_BIT = 1;
	localparam logic [4:0] MOD_PIN_IDLE = 5'h1F;

	// ----------------------------------------------------------------
	// Host controller registers
	// ----------------------------------------------------------------
	localparam logic [3:0] H_CTRL = 4'h0;
	localparam logic [3:0] H_PTR = 4'h1;
	localparam logic [3:0] H_WDATA = 4'h2;
	localparam logic [3:0] H_CMD = 4'h3;
	localparam logic [3:0] H_RDATA = 4'h4;
	localparam logic [3:0] H_STATUS = 4'h5;
	localparam logic [3:0] H_IRQ_STAT = 4'h6;
	localparam logic [3:0] H_IRQ_CLR = 4'h7;
	localparam logic [3:0] H_IRQ_EN = 4'h8;
	localparam logic [3:0] H_CTRL_RST = 4'h0;
	localparam int CTRL_SEL_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam int CTRL_INIT_OE_BIT = 2;
	localparam int CTRL_INIT_BIT = 3;
	localparam int CMD_READ_BIT = 0;
	localparam int CMD_DATA_BIT = 1;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ATTN_BIT = 1;
	localparam int IRQ_PRES_BIT = 2;
	localparam logic [2:0] HOST_PIN_IDLE = 3'h7;

	typedef enum logic [3:0] {
		SLV_IDLE = 4'h0,
		SLV_ADDR = 4'h1,
		SLV_ADDR_ACK = 4'h2,
		SLV_PTR = 4'h3,
		SLV_PTR_ACK = 4'h4,
		SLV_WR = 4'h5,
		SLV_WR_ACK = 4'h6,
		SLV_RD = 4'h7,
		SLV_RD_ACK = 4'h8
	} plc_slv_e;

	typedef enum logic [2:0] {
		MST_IDLE = 3'h0,
		MST_START = 3'h1,
		MST_BIT = 3'h2,
		MST_ACK = 3'h3,
		MST_STOP = 3'h4
	} plc_mst_e;
endpackage : plc_pkg

// >>> testbench.sv
// Self-checking bench joining host and module ends over the link.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [3:0] CT = plc_pkg::H_CTRL;
	localparam logic [3:0] ST = plc_pkg::H_STATUS;
	localparam logic [3:0] IS = plc_pkg::H_IRQ_STAT;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [7:0] fault_i = 8'h00;
	logic [7:0] rdata_o;
	logic irq_o;
	logic high_power_o;
	logic ready_o;
	logic [7:0] d;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	plc_link_if link_if ();
	plc_host #(.QUARTER_CYC(8)) u_plc_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o));
	plc_module #(.RESET_MIN_CYC(20), .INIT_CYC(10)) u_plc_module (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.link(link_if), .fault_i(fault_i), .high_power_o(high_power_o), .ready_o(ready_o));
	plc_link_chk #(.RESET_MIN_CYC(20)) u_plc_link_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl(link_if.scl),
		.module_select_n(link_if.module_select_n), .module_reset_n(link_if.module_reset_n),
		.host_init_oe(link_if.host_init_oe), .init_control_select(link_if.init_control_select),
		.attention_n(link_if.attention_n), .module_present_n(link_if.module_present_n),
		.mod_sda_oe(link_if.mod_sda_oe), .mod_attn_oe(link_if.mod_attn_oe), .mod_present_oe(link_if.mod_present_oe));
	always #10 clk_i = ~clk_i;
	task automatic print_verdict();
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// A hang in a bus operation ends the run here.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		cmp_count++;
		if ((got & m) !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got & m, exp);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
		rd(a);
		chk(d, exp, m);
	endtask : rchk
	task automatic op(input logic [7:0] c);
		wr(plc_pkg::H_CMD, c);
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 3000; i++) begin
			rd(ST);
			if (d[0] !== 1'b1) break;
		end
		chk(d, 8'h00, 8'h01);
	endtask : op
	task automatic mchk(input logic [7:0] p, input logic [7:0] exp, input logic [7:0] m);
		wr(plc_pkg::H_PTR, p);
		op(8'h00);
		op(8'h01);
		rchk(plc_pkg::H_RDATA, exp, m);
	endtask : mchk
	task automatic mwr(input logic [7:0] p, input logic [7:0] v);
		wr(plc_pkg::H_PTR, p);
		wr(plc_pkg::H_WDATA, v);
		op(8'h02);
	endtask : mwr
	initial begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		wr(plc_pkg::H_IRQ_EN, 8'h07);
		repeat (60) @(posedge clk_i);
		rchk(IS, 8'h06, 8'h07);
		rchk(ST, 8'h0C, 8'h1F);
		chk({7'h00, irq_o}, 8'h01, 8'h01);
		chk({7'h00, ready_o}, 8'h01, 8'h01);
		rchk(4'hF, 8'h00, 8'hFF);
		op(8'h01);
		rchk(ST, 8'h02, 8'h03);
		wr(CT, 8'h01);
		mchk(plc_pkg::MAP_STATUS, 8'h02, 8'h03);
		repeat (8) @(posedge clk_i);
		rchk(ST, 8'h00, 8'h08);
		rchk(IS, 8'h01, 8'h01);
		mchk(plc_pkg::MAP_MODE, 8'h01, 8'h03);
		mwr(plc_pkg::MAP_CONTROL, 8'h01);
		mchk(plc_pkg::MAP_MODE, 8'h03, 8'h03);
		wr(CT, 8'h03);
		wr(CT, 8'h01);
		mchk(plc_pkg::MAP_CONTROL, 8'h01, 8'h01);
		wr(plc_pkg::H_IRQ_CLR, 8'h07);
		wr(CT, 8'h07);
		repeat (40) @(posedge clk_i);
		rchk(ST, 8'h10, 8'h18);
		chk({6'h00, ready_o, high_power_o}, 8'h00, 8'h03);
		wr(CT, 8'h05);
		repeat (80) @(posedge clk_i);
		rchk(IS, 8'h02, 8'h07);
		mchk(plc_pkg::MAP_CONTROL, 8'h00, 8'h01);
		mchk(plc_pkg::MAP_MODE, 8'h02, 8'h03);
		chk({7'h00, high_power_o}, 8'h01, 8'h01);
		mchk(plc_pkg::MAP_STATUS, 8'h00, 8'h01);
		wr(plc_pkg::H_IRQ_CLR, 8'h07);
		fault_i <= 8'h04;
		@(posedge clk_i);
		fault_i <= 8'h00;
		repeat (20) @(posedge clk_i);
		rchk(IS, 8'h02, 8'h07);
		chk({7'h00, irq_o}, 8'h01, 8'h01);
		mchk(plc_pkg::MAP_FAULT, 8'h04, 8'hFF);
		mchk(plc_pkg::MAP_FAULT, 8'h00, 8'hFF);
		wr(plc_pkg::H_IRQ_EN, 8'h00);
		repeat (3) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, 8'h01);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
